// File: brkm_cmp.sv
`timescale 1ns/10ps
// Registered 16-bit program counter compare
module brkm_cmp (
	input  wire logic        clk_sys,  // System clock
	input  wire logic        nrst,     // Async reset, active low
	input  wire logic [15:0] pc_addr,  // CPU program counter address
	input  wire logic        pc_valid, // Address is a program counter fetch
	input  wire logic [15:0] bp_addr,  // Breakpoint address
	output logic             hit       // Comparison matched
);
	// Only program counter cycles may match, data cycles never
	wire is_hit = pc_valid && (pc_addr == bp_addr);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) hit <= 1'b0;
		else hit <= is_hit;
	end
endmodule

// File: brkm_cpu_model.sv
`timescale 1ns/10ps
// CPU stand-in: instruction boundaries, break acknowledge and return
module brkm_cpu_model (
	input  wire logic clk_sys,     // System clock
	input  wire logic nrst,        // Async reset, active low
	input  wire logic slow,        // Late acknowledge
	input  wire logic break_req,   // Break request from the unit
	output logic      instr_last,  // Last cycle of an instruction
	output logic      cpu_swi_ack, // Interrupt opcode load begins
	output logic      cpu_rti      // Break routine returns
);
	logic [1:0] phase;    // Cycle within a four-cycle instruction
	logic [5:0] wait_cnt; // Delay before acknowledge or return
	logic       served;   // Acknowledge given, return pending

	// Fixed instruction length; return comes long after acknowledge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase <= 2'h0;
			wait_cnt <= 6'h00;
			served <= 1'b0;
			instr_last <= 1'b0;
			cpu_swi_ack <= 1'b0;
			cpu_rti <= 1'b0;
		end else begin
			phase <= phase + 2'h1;
			instr_last <= (phase == 2'h2);
			cpu_swi_ack <= 1'b0;
			cpu_rti <= 1'b0;
			if (break_req && !served) begin
				wait_cnt <= wait_cnt + 6'h01;
				if (wait_cnt == (slow ? 6'h08 : 6'h01)) begin
					cpu_swi_ack <= 1'b1;
					served <= 1'b1;
					wait_cnt <= 6'h00;
				end
			end else if (served) begin
				wait_cnt <= wait_cnt + 6'h01;
				if (wait_cnt == 6'h3F) begin
					cpu_rti <= 1'b1;
					served <= 1'b0;
					wait_cnt <= 6'h00;
				end
			end
		end
	end
endmodule

// File: brkm_pkg.sv
package brkm_pkg;
	// Register indices on the plain register port
	localparam logic [2:0] BRKM_OFS_WAKE   = 3'h0; // Wake status
	localparam logic [2:0] BRKM_OFS_FLGCLR = 3'h3; // Flag clear control
	localparam logic [2:0] BRKM_OFS_ADDRH  = 3'h1; // Address high byte
	localparam logic [2:0] BRKM_OFS_ADDRL  = 3'h2; // Address low byte
	localparam logic [2:0] BRKM_OFS_CTRL   = 3'h4; // Control and status
	localparam logic [2:0] BRKM_OFS_ISTAT  = 3'h5; // Interrupt status
	localparam logic [2:0] BRKM_OFS_IMASK  = 3'h6; // Interrupt mask
	// Field positions
	localparam int BRKM_BIT_ENABLE = 7; // Address match enable
	localparam int BRKM_BIT_ACTIVE = 6; // Break active flag
	localparam int BRKM_BIT_WAITX  = 1; // Wait exit flag
	localparam int BRKM_BIT_FCLR   = 7; // Flag clear in break enable
	localparam int BRKM_BIT_WAKE   = 4; // Fixed one in wake status
	// Reset values
	localparam logic [7:0] BRKM_RST_BYTE = 8'h00; // Address and control
	localparam logic [7:0] BRKM_WAKE_FIX = 8'h10; // Wake status read constant
	localparam logic       BRKM_RST_FCLR_OK = 1'b1; // Flags clearable out of reset
	// Break vector fetch addresses
	localparam logic [15:0] BRKM_VEC_NORM = 16'hFFFC; // Normal vector pair
	localparam logic [15:0] BRKM_VEC_MON  = 16'hFEFC; // Monitor mode pair
	// Interrupt event bits
	localparam int BRKM_EV_MATCH = 0; // Address match break
	localparam int BRKM_EV_SOFT  = 1; // Forced break
	localparam int BRKM_EV_WAKE  = 2; // Break ended low power
	localparam int BRKM_NEV      = 3; // Event count
endpackage

// File: brkm_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser for one pin level
module brkm_sync (
	input  wire logic clk_sys, // System clock
	input  wire logic nrst,    // Async reset, active low
	input  wire logic din,     // Asynchronous pin level
	output logic      dout     // Filtered level
);
	logic s1; // First stage, read only by s2
	logic s2; // Second stage
	logic s3; // Third stage

	// Chain; output moves only when stages two and three agree
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule

// File: brkm_top.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
// Breakpoint address match unit
module brkm_top
	import brkm_pkg::*;
(
	input  wire logic        clk_sys,      // System clock, 100 MHz
	input  wire logic        nrst,         // Async reset, active low
	input  wire logic [2:0]  reg_addr,     // Register index
	input  wire logic [7:0]  reg_wdata,    // Write data
	input  wire logic        reg_wr,       // Write strobe
	input  wire logic        reg_rd,       // Read strobe
	output logic      [7:0]  reg_rdata,    // Read data, cycle after strobe
	input  wire logic [15:0] pc_addr,      // CPU address bus
	input  wire logic        pc_valid,     // Address is a program counter fetch
	input  wire logic        instr_last,   // Last cycle of an instruction
	input  wire logic        cpu_swi_ack,  // CPU began software interrupt
	input  wire logic        cpu_rti,      // CPU executed return from interrupt
	input  wire logic        in_wait,      // CPU in wait mode
	input  wire logic        in_stop,      // CPU in stop mode
	input  wire logic        monitor_mode, // Monitor mode strap
	input  wire logic        test_voltage, // Reset pin at test voltage
	output logic             break_req,    // Break request to CPU
	output logic [15:0]      break_vector, // Vector fetch address
	output logic             timer_halt,   // Halt both timer modules
	output logic             wdog_disable, // Hold watchdog off
	output logic             wake_req,     // Exit wait or stop mode
	output logic             flag_clr_ok,  // Other modules may clear flags
	output logic             irq           // Unmasked event pending
);
	import brkm_pkg::*;

	// Register state
	logic [7:0] addr_hi;      // Breakpoint high byte
	logic [7:0] addr_lo;      // Breakpoint low byte
	logic       match_en;     // Address match enable
	logic       active;       // Break active flag
	logic       wait_exit;    // Wait exit flag
	logic       fclr_en;      // Flag clear in break enable
	logic [BRKM_NEV-1:0] istat; // Sticky event status
	logic [BRKM_NEV-1:0] imask; // Event mask
	logic       in_break;     // Break service in progress
	logic       pend;         // Hit waiting for instruction end
	logic       tv_sync;      // Synchronised test voltage
	logic       hit;          // Registered compare hit

	// Test voltage arrives from a pin
	brkm_sync u_tv (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.din     (test_voltage),
		.dout    (tv_sync)
	);

	brkm_cmp u_cmp (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.pc_addr  (pc_addr),
		.pc_valid (pc_valid),
		.bp_addr  ({addr_hi, addr_lo}),
		.hit      (hit)
	);

	// Decode
	wire wr_ctrl  = reg_wr && (reg_addr == BRKM_OFS_CTRL);
	wire wr_hi    = reg_wr && (reg_addr == BRKM_OFS_ADDRH);
	wire wr_lo    = reg_wr && (reg_addr == BRKM_OFS_ADDRL);
	wire wr_wake  = reg_wr && (reg_addr == BRKM_OFS_WAKE);
	wire wr_fclr  = reg_wr && (reg_addr == BRKM_OFS_FLGCLR);
	wire wr_imask = reg_wr && (reg_addr == BRKM_OFS_IMASK);
	wire rd_istat = reg_rd && (reg_addr == BRKM_OFS_ISTAT);

	// Enabled match event; compare keeps running in wait mode too
	wire match_ev = hit && match_en;
	// Forced break by writing a one to the active flag
	wire soft_ev  = wr_ctrl && reg_wdata[BRKM_BIT_ACTIVE];
	// Mid-instruction hit waits; last cycle or idle CPU fires at once
	wire fire_now = (match_ev || pend) && (instr_last || in_wait || in_stop);
	wire start    = fire_now || soft_ev; // Break begins
	// Break ending low power: requested while CPU sleeps
	wire wake_ev  = start && (in_wait || in_stop);
	wire [BRKM_NEV-1:0] ev = {wake_ev, soft_ev, fire_now};

	// Pending hit until instruction boundary
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) pend <= 1'b0;
		else pend <= (match_ev || pend) && !fire_now;
	end

	// Break request held until the CPU takes it
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) break_req <= 1'b0;
		else if (start) break_req <= 1'b1;
		else if (cpu_swi_ack) break_req <= 1'b0;
	end

	// Break state from acknowledge to return
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) in_break <= 1'b0;
		else if (cpu_swi_ack) in_break <= 1'b1;
		else if (cpu_rti) in_break <= 1'b0;
	end

	// Control register; hardware set beats software clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			match_en <= 1'b0;
			active   <= 1'b0;
		end else begin
			if (wr_ctrl) match_en <= reg_wdata[BRKM_BIT_ENABLE];
			// Routine must clear this before return; not forced here
			if (start) active <= 1'b1;
			else if (wr_ctrl) active <= reg_wdata[BRKM_BIT_ACTIVE];
		end
	end

	// Address bytes
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_hi <= BRKM_RST_BYTE;
			addr_lo <= BRKM_RST_BYTE;
		end else begin
			if (wr_hi) addr_hi <= reg_wdata;
			if (wr_lo) addr_lo <= reg_wdata;
		end
	end

	// Wait exit flag: software writes zero only to clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) wait_exit <= 1'b0;
		else if (wake_ev) wait_exit <= 1'b1;
		else if (wr_wake && !reg_wdata[BRKM_BIT_WAITX]) wait_exit <= 1'b0;
	end
	// Software reads this to rewind its return address
	// relies on wait_exit staying until written zero

	// Flag clear enable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) fclr_en <= 1'b0;
		else if (wr_fclr) fclr_en <= reg_wdata[BRKM_BIT_FCLR];
	end

	// Interrupt status and mask; read clears, new event wins
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			istat <= '0;
			imask <= '0;
		end else begin
			istat <= (rd_istat ? '0 : istat) | ev;
			if (wr_imask) imask <= reg_wdata[BRKM_NEV-1:0];
		end
	end

	// Read mux, unmapped reads zero
	logic [7:0] rd_mux; // Selected register
	always_comb begin
		case (reg_addr)
			BRKM_OFS_CTRL:   rd_mux = {match_en, active, 6'h00};
			BRKM_OFS_ADDRH:  rd_mux = addr_hi;
			BRKM_OFS_ADDRL:  rd_mux = addr_lo;
			BRKM_OFS_WAKE:   rd_mux = BRKM_WAKE_FIX | {6'h00, wait_exit, 1'b0};
			BRKM_OFS_FLGCLR: rd_mux = {fclr_en, 7'h00};
			BRKM_OFS_ISTAT:  rd_mux = {5'h00, istat};
			BRKM_OFS_IMASK:  rd_mux = {5'h00, imask};
			default:         rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) reg_rdata <= 8'h00;
		else if (reg_rd) reg_rdata <= rd_mux;
	end

	// Registered system outputs; break covers request and service
	wire brk_state = in_break || break_req || active;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			timer_halt   <= 1'b0;
			wdog_disable <= 1'b0;
			wake_req     <= 1'b0;
			flag_clr_ok  <= BRKM_RST_FCLR_OK;
			irq          <= 1'b0;
			break_vector <= BRKM_VEC_NORM;
		end else begin
			timer_halt   <= brk_state;
			wdog_disable <= brk_state && tv_sync;
			wake_req     <= wake_ev;
			flag_clr_ok  <= !brk_state || fclr_en;
			irq          <= |(((rd_istat ? '0 : istat) | ev) & imask);
			// Vector pair chosen by monitor mode
			break_vector <= monitor_mode ? BRKM_VEC_MON : BRKM_VEC_NORM;
		end
	end

	// Assertions
	a_req_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
		break_req && !cpu_swi_ack && !start |=> break_req)
		else $error("break request dropped early");
	a_soft_break: assert property (@(posedge clk_sys) disable iff (!nrst)
		soft_ev |=> break_req && active)
		else $error("forced break missing");
	a_match_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
		!match_en && !pend && !soft_ev |=> !$rose(break_req))
		else $error("break while disabled");
	a_timer_halt: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_break |=> timer_halt)
		else $error("timers not halted");
	a_wdog_test: assert property (@(posedge clk_sys) disable iff (!nrst)
		wdog_disable |-> $past(brk_state) && $past(tv_sync))
		else $error("watchdog off without cause");
	a_wake_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
		start && in_wait |=> wait_exit && wake_req)
		else $error("wait exit flag missing");
	a_flag_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
		in_break && !fclr_en |=> !flag_clr_ok)
		else $error("flags clearable in break");
	a_pend_fire: assert property (@(posedge clk_sys) disable iff (!nrst)
		pend && instr_last |=> break_req)
		else $error("break not at boundary");
	a_addr_reset: assert property (@(posedge clk_sys)
		$rose(nrst) |-> addr_hi == 8'h00 && addr_lo == 8'h00)
		else $error("address not zero");

	// Single-cycle behaviours, named once and used below
	// Forced break: a control write with the active bit high
	sequence s_soft_write;
		wr_ctrl && reg_wdata[BRKM_BIT_ACTIVE];
	endsequence
	// Hit that lands mid-instruction on a running CPU
	sequence s_late_hit;
		match_ev && !instr_last && !in_wait && !in_stop;
	endsequence
	// Break raised while the CPU sleeps in stop mode
	sequence s_stop_break;
		start && in_stop;
	endsequence

	// A request never appears without a cause
	a_req_rise: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(break_req) |-> $past(start))
		else $error("break request without cause");

	// Only the acknowledge may take the request away
	a_req_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
		$fell(break_req) |-> $past(cpu_swi_ack))
		else $error("break request dropped without acknowledge");

	// Pending hit is consumed at the boundary
	a_pend_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		pend && instr_last |=> !pend)
		else $error("pending hit not consumed");

	// Mid-instruction hit is remembered, not lost
	a_late_pend: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_late_hit |=> pend)
		else $error("late hit not pending");

	// Mid-instruction hit must not break early
	a_late_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
		match_ev && !instr_last && !in_wait && !in_stop && !pend && !soft_ev |=> !$rose(break_req))
		else $error("break before instruction end");

	// Pending hit waits across non-final cycles
	a_pend_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
		pend && !instr_last && !in_wait && !in_stop |=> pend)
		else $error("pending hit lost");

	// Hit on a final cycle breaks and flags at once
	a_active_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		match_ev && (instr_last || in_wait || in_stop) |=> active && break_req)
		else $error("match did not set active flag");

	// Forced break sets the active flag
	a_soft_active: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_soft_write |=> active)
		else $error("forced break did not set active flag");

	// Address bytes take the written value
	a_hi_write: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_hi |=> addr_hi == $past(reg_wdata))
		else $error("address high byte not written");

	a_lo_write: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_lo |=> addr_lo == $past(reg_wdata))
		else $error("address low byte not written");

	// Enable follows bit seven of a control write
	a_en_set: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_ctrl && reg_wdata[BRKM_BIT_ENABLE] |=> match_en)
		else $error("enable not set");

	a_en_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_ctrl && !reg_wdata[BRKM_BIT_ENABLE] |=> !match_en)
		else $error("enable not cleared");

	// Wait exit flag is sticky until written zero
	a_wait_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		wait_exit && !wr_wake |=> wait_exit)
		else $error("wait exit flag lost");

	a_wait_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
		wr_wake && !reg_wdata[BRKM_BIT_WAITX] && !wake_ev |=> !wait_exit)
		else $error("wait exit flag not cleared");

	// Break in stop mode wakes the part and flags it
	a_stop_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_stop_break |=> wake_req && wait_exit)
		else $error("stop exit missing");

	// Timers halt while the flag or request stands
	a_halt_active: assert property (@(posedge clk_sys) disable iff (!nrst)
		active || break_req |=> timer_halt)
		else $error("timers run during break");

	// Without the test voltage the watchdog stays on
	a_wdog_no_tv: assert property (@(posedge clk_sys) disable iff (!nrst)
		!tv_sync |=> !wdog_disable)
		else $error("watchdog off without test voltage");

	// Outside a break, flags may always be cleared
	a_flag_free: assert property (@(posedge clk_sys) disable iff (!nrst)
		!in_break && !break_req && !active |=> flag_clr_ok)
		else $error("flags locked outside break");

	// Data cycles never produce a hit
	a_pc_only: assert property (@(posedge clk_sys) disable iff (!nrst)
		!pc_valid |=> !hit)
		else $error("hit on a non-fetch cycle");

	// Vector pair follows the monitor strap
	a_vec_mon: assert property (@(posedge clk_sys) disable iff (!nrst)
		monitor_mode |=> break_vector == BRKM_VEC_MON)
		else $error("monitor vector wrong");

	a_vec_norm: assert property (@(posedge clk_sys) disable iff (!nrst)
		!monitor_mode |=> break_vector == BRKM_VEC_NORM)
		else $error("normal vector wrong");
endmodule

// File: brkm_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
// Register-level bench for the breakpoint unit
module brkm_top_tb;
	import brkm_pkg::*;
	logic        clk_sys, nrst, reg_wr, reg_rd, pc_valid, in_wait, in_stop; // Drives
	logic        monitor_mode, test_voltage, slow;                        // Straps
	logic [2:0]  reg_addr;                                                // Register index
	logic [7:0]  reg_wdata, reg_rdata;                                    // Register data
	logic [15:0] pc_addr, break_vector;                                   // Addresses
	logic        instr_last, cpu_swi_ack, cpu_rti, break_req, timer_halt; // CPU side
	logic        wdog_disable, wake_req, flag_clr_ok, irq;                // Status outputs
	logic [3:0]  wake_cnt;                                                // Wake pulses seen
	int          fails, total_checks;                                     // Tallies

	brkm_top dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_addr(pc_addr), .pc_valid(pc_valid),
		.instr_last(instr_last), .cpu_swi_ack(cpu_swi_ack), .cpu_rti(cpu_rti), .in_wait(in_wait),
		.in_stop(in_stop), .monitor_mode(monitor_mode), .test_voltage(test_voltage), .break_req(break_req),
		.break_vector(break_vector), .timer_halt(timer_halt), .wdog_disable(wdog_disable),
		.wake_req(wake_req), .flag_clr_ok(flag_clr_ok), .irq(irq));
	brkm_cpu_model cpu (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .break_req(break_req),
		.instr_last(instr_last), .cpu_swi_ack(cpu_swi_ack), .cpu_rti(cpu_rti));

	// Clock, 100 MHz
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// One-cycle wake pulses are counted, not sampled
	always @(posedge clk_sys) if (wake_req === 1'b1) wake_cnt <= wake_cnt + 4'h1;

	task automatic complete_run;
		if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata, e)
	endtask
	// Bounded wait for the request level
	task automatic wait_req(input logic v);
		int n;
		for (n = 0; n < 50 && break_req !== v; n++) @(posedge clk_sys);
		`CHK(break_req, v)
	endtask
	// Service routine: clear the active flag, then let the return happen
	task automatic serve;
		wr(BRKM_OFS_CTRL, 8'h80);
		repeat (80) @(posedge clk_sys);
	endtask
	// Hang guard
	initial begin
		#300000;
		fails++;
		complete_run();
	end

	initial begin
		{nrst, reg_wr, reg_rd, pc_valid, in_wait, in_stop, monitor_mode, test_voltage, slow} = 9'h000;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		pc_addr = 16'h0000;
		wake_cnt = 4'h0;
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		rd(BRKM_OFS_WAKE, 8'h10);
		rd(BRKM_OFS_ADDRH, 8'h00);
		rd(BRKM_OFS_ADDRL, 8'h00);
		rd(BRKM_OFS_CTRL, 8'h00);
		rd(BRKM_OFS_FLGCLR, 8'h00);
		rd(3'h7, 8'h00);
		`CHK(flag_clr_ok, 1'b1)
		`CHK(break_vector, 16'hFFFC)
		wr(BRKM_OFS_ADDRH, 8'h12);
		wr(BRKM_OFS_ADDRL, 8'h34);
		rd(BRKM_OFS_ADDRH, 8'h12);
		rd(BRKM_OFS_ADDRL, 8'h34);
		wr(BRKM_OFS_IMASK, 8'h07);
		// Matching fetch while disabled, then a matching non-fetch address
		pc_addr <= 16'h1234;
		pc_valid <= 1'b1;
		test_voltage <= 1'b1;
		slow <= 1'b1;
		repeat (10) @(posedge clk_sys);
		`CHK(break_req, 1'b0)
		pc_valid <= 1'b0;
		wr(BRKM_OFS_CTRL, 8'h80);
		repeat (10) @(posedge clk_sys);
		`CHK(break_req, 1'b0)
		// One matching fetch, enabled
		pc_valid <= 1'b1;
		@(posedge clk_sys);
		pc_valid <= 1'b0;
		wait_req(1'b1);
		repeat (4) @(posedge clk_sys);
		`CHK(break_req, 1'b1)
		`CHK(timer_halt, 1'b1)
		`CHK(wdog_disable, 1'b1)
		`CHK(flag_clr_ok, 1'b0)
		`CHK(irq, 1'b1)
		rd(BRKM_OFS_CTRL, 8'hC0);
		rd(BRKM_OFS_ISTAT, 8'h01);
		`CHK(irq, 1'b0)
		wait_req(1'b0);
		serve();
		rd(BRKM_OFS_CTRL, 8'h80);
		`CHK(timer_halt, 1'b0)
		// Forced break from wait, flag clearing allowed
		slow <= 1'b0;
		wr(BRKM_OFS_FLGCLR, 8'h80);
		rd(BRKM_OFS_FLGCLR, 8'h80);
		in_wait <= 1'b1;
		wr(BRKM_OFS_CTRL, 8'hC0);
		wait_req(1'b1);
		in_wait <= 1'b0;
		#1 `CHK(wake_cnt, 4'h1)
		`CHK(flag_clr_ok, 1'b1)
		rd(BRKM_OFS_WAKE, 8'h12);
		wr(BRKM_OFS_WAKE, 8'h00);
		rd(BRKM_OFS_WAKE, 8'h10);
		rd(BRKM_OFS_ISTAT, 8'h06);
		serve();
		// Forced break from stop
		in_stop <= 1'b1;
		wr(BRKM_OFS_CTRL, 8'hC0);
		wait_req(1'b1);
		in_stop <= 1'b0;
		#1 `CHK(wake_cnt, 4'h2)
		rd(BRKM_OFS_WAKE, 8'h12);
		wr(BRKM_OFS_WAKE, 8'h00);
		serve();
		monitor_mode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK(break_vector, 16'hFEFC)
		complete_run();
	end
endmodule
